// file: shared/lmf_pkg.sv
// Package of the LED matrix font, scan and brightness register block.
// Assumes one 25 MHz clock; shared by the register block and its font RAM.
package lmf_pkg;

  // ----------------------------------------------------------------
  // Register addresses (address byte of a serial frame)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BRIGHT_01 = 7'h01;
  localparam logic [6:0] ADDR_BRIGHT_23 = 7'h02;
  localparam logic [6:0] ADDR_SCAN = 7'h03;
  localparam logic [6:0] ADDR_GLYPH_PORT = 7'h05;
  localparam int READ_FLAG_BIT = 7;
  localparam int SCAN_FOUR_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and font pointer limits
  // ----------------------------------------------------------------
  localparam logic [7:0] BRIGHT_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET = 8'h00;
  localparam logic [7:0] PTR_FIRST = 8'h80;
  localparam logic [7:0] PTR_LAST = 8'hF7;
  localparam logic [7:0] PTR_INVALID = 8'hF8;
  localparam int GLYPH_COLUMNS = 5;
  localparam int FONT_ENTRIES = 120;
  localparam int FONT_AW = 7;
  localparam int FONT_DW = 7;

  // ----------------------------------------------------------------
  // Frame and timing counts
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] ADDR_BITS = 5'd8;
  localparam logic [7:0] SLOT_CYCLES = 8'd64;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [4:0] DUTY_MAX = 5'd15;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b10
  } lmf_frame_type;

  // Brightness code to on-slots out of 16; the top two codes share 15
  function automatic logic [4:0] lmf_duty(input logic [3:0] code);
    lmf_duty = (code == 4'hF) ? DUTY_MAX : ({1'b0, code} + 5'd1);
  endfunction

endpackage

// file: shared/lmf_font_if.sv
// Interface between the register block and the user glyph RAM.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface lmf_font_if;
  import lmf_pkg::*;
  logic wrEn;
  logic [FONT_AW-1:0] addr;
  logic [FONT_DW-1:0] wrData;
  logic [FONT_DW-1:0] rdData;
  modport ctrl (output wrEn, output addr, output wrData, input rdData);
  modport ram (input wrEn, input addr, input wrData, output rdData);
endinterface

// file: rtl/lmf_font_ram.sv
// User glyph RAM: 120 columns of 7 bits, registered read data.
// Assumes synchronous active-high reset and a single clock.
`timescale 1ns/1ps
module lmf_font_ram (
  input wire logic clock,
  input wire logic sys_rst,
  lmf_font_if.ram port
);
  import lmf_pkg::*;

  typedef struct packed {
    logic [FONT_ENTRIES-1:0][FONT_DW-1:0] cells;
    logic [FONT_DW-1:0] rdData;
  } lmf_ram_state_type;

  lmf_ram_state_type ram_r;
  lmf_ram_state_type ram_nxt;

  // ----------------------------------------------------------------
  // Next state: read returns the old word on a same-cycle write
  // ----------------------------------------------------------------
  always_comb begin
    ram_nxt = ram_r;
    ram_nxt.rdData = ram_r.cells[port.addr];
    if (port.wrEn) begin
      ram_nxt.cells[port.addr] = port.wrData;
    end
  end

  // Cleared at reset so reads never return unknown glyphs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ram_r <= '0;
    end else begin
      ram_r <= ram_nxt;
    end
  end

  assign port.rdData = ram_r.rdData;

endmodule

// file: rtl/lmf_regs.sv
// Register block of a 4-digit dot-matrix driver: serial port, glyph pointer,
// scan limit and per-digit brightness PWM. Assumes a 25 MHz clock and that
// the serial clock runs at most one eighth of it.
//
// Overview of operation
// R1: Glyph port write with top bit set loads the font pointer.
// R2: Glyph port write with top bit clear stores seven bits, pointer advances.
// R3: Each glyph is five consecutive entries; glyphs start at 0x80, 0x85, 0x8A.
// R4: Host sets glyph base pointer, then writes five columns in order.
// R5: Scan bit D0 clear drives digits zero and one only; D7-D1 ignored.
// R6: Scan bit D0 set multiplexes all four digits.
// R7: Low nibbles of 0x01/0x02 set duty of digits 0/2, (n+1)/16, max 15/16.
// R8: High nibbles of 0x01/0x02 set duty of digits 1/3, same coding.
// R9: Pointer wraps from 0xF7 to 0x80; loads of 0xF8-0xFF give 0x80.
// R10: Read at 0x85 returns entry with top bit clear, then advances pointer.
// R11: Host changes scan limit only in shutdown; no shutdown state here, scan writes are accepted at any time.
`timescale 1ns/1ps
module lmf_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDin,
  output logic spiDout,
  output logic [3:0] digitDrive
);
  import lmf_pkg::*;

  typedef struct packed {
    logic [2:0] sclkSync;
    logic [2:0] csSync;
    logic [1:0] dinSync;
    lmf_frame_type frame;
    logic [4:0] bitCnt;
    logic [15:0] shiftIn;
    logic [7:0] shiftOut;
    logic [7:0] bright01;
    logic [7:0] bright23;
    logic [7:0] scanLimit;
    logic [7:0] fontPtr;
    logic [7:0] divCnt;
    logic [3:0] slot;
    logic pairSel;
    logic [3:0] digitOn;
  } lmf_state_type;

  lmf_state_type st_r;
  lmf_state_type st_nxt;
  lmf_font_if fontBus ();

  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;
  logic frameDone;
  logic [7:0] cmdAddr;
  logic [7:0] cmdData;
  logic glyphWrite;
  logic glyphRead;
  logic slotTick;
  logic [7:0] ptrNext;
  logic [3:0] digitOnNxt;

  lmf_font_ram fontRam (
    .clock(clock),
    .sys_rst(sys_rst),
    .port(fontBus.ram)
  );

  // ----------------------------------------------------------------
  // Pin edges, seen only on the second and third sync stages
  // ----------------------------------------------------------------
  assign sclkRise = st_r.sclkSync[1] & ~st_r.sclkSync[2];
  assign sclkFall = ~st_r.sclkSync[1] & st_r.sclkSync[2];
  assign csFall = ~st_r.csSync[1] & st_r.csSync[2];
  assign csRise = st_r.csSync[1] & ~st_r.csSync[2];
  // Short frames are dropped; long ones keep their last 16 bits
  assign frameDone = csRise && (st_r.bitCnt == FRAME_BITS);
  assign cmdAddr = st_r.shiftIn[15:8];
  assign cmdData = st_r.shiftIn[7:0];
  assign glyphWrite = frameDone && !cmdAddr[READ_FLAG_BIT] && (cmdAddr[6:0] == ADDR_GLYPH_PORT);
  assign glyphRead = frameDone && cmdAddr[READ_FLAG_BIT] && (cmdAddr[6:0] == ADDR_GLYPH_PORT);
  assign slotTick = (st_r.divCnt == SLOT_CYCLES - 8'd1);
  // Pointer step shared by data write and read
  assign ptrNext = (st_r.fontPtr == PTR_LAST) ? PTR_FIRST : st_r.fontPtr + 8'd1; // [R9] [R3]

  // ----------------------------------------------------------------
  // Font RAM port: address follows the pointer, so a read is ready
  // long before the data byte goes out
  // ----------------------------------------------------------------
  assign fontBus.addr = st_r.fontPtr[FONT_AW-1:0];
  assign fontBus.wrData = cmdData[FONT_DW-1:0];
  assign fontBus.wrEn = glyphWrite && !cmdData[7]; // [R2]

  // Per-digit PWM compare; odd digits use the high nibble
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gDigit
      logic [7:0] brightReg;
      logic [3:0] code;
      assign brightReg = (gi < 2) ? st_r.bright01 : st_r.bright23;
      assign code = (gi % 2 == 1) ? brightReg[7:4] : brightReg[3:0]; // [R7] [R8]
      assign digitOnNxt[gi] = (st_r.pairSel == (gi >= 2))
                              && ((gi < 2) || st_r.scanLimit[SCAN_FOUR_BIT]) // [R5]
                              && ({1'b0, st_r.slot} < lmf_duty(code)); // [R7] [R8]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclkSync = {st_r.sclkSync[1:0], spiClk};
    st_nxt.csSync = {st_r.csSync[1:0], spiCsN};
    st_nxt.dinSync = {st_r.dinSync[0], spiDin};
    st_nxt.digitOn = digitOnNxt;

    // Frame tracking; chip select high aborts any frame
    case (st_r.frame)
      FR_IDLE: begin
        st_nxt.shiftOut = 8'h00;
      end
      FR_ADDR: begin
        if (sclkRise) begin
          st_nxt.shiftIn = {st_r.shiftIn[14:0], st_r.dinSync[1]};
          st_nxt.bitCnt = st_r.bitCnt + 5'd1;
          if (st_r.bitCnt == ADDR_BITS - 5'd1) begin
            st_nxt.frame = FR_DATA;
          end
        end
      end
      FR_DATA: begin
        if (sclkRise) begin
          st_nxt.shiftIn = {st_r.shiftIn[14:0], st_r.dinSync[1]};
          if (st_r.bitCnt != FRAME_BITS) begin
            st_nxt.bitCnt = st_r.bitCnt + 5'd1;
          end
        end
        // Answer byte loads on the falling edge after the address byte
        if (sclkFall && st_r.bitCnt == ADDR_BITS && st_r.shiftIn[READ_FLAG_BIT]) begin
          case (st_r.shiftIn[6:0])
            ADDR_BRIGHT_01: st_nxt.shiftOut = st_r.bright01;
            ADDR_BRIGHT_23: st_nxt.shiftOut = st_r.bright23;
            ADDR_SCAN: st_nxt.shiftOut = st_r.scanLimit;
            ADDR_GLYPH_PORT: st_nxt.shiftOut = {1'b0, fontBus.rdData}; // [R10]
            default: st_nxt.shiftOut = 8'h00;
          endcase
        end else if (sclkFall && st_r.bitCnt > ADDR_BITS) begin
          st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
        end
      end
      default: begin
        st_nxt.frame = FR_IDLE;
      end
    endcase
    if (csFall) begin
      st_nxt.frame = FR_ADDR;
      st_nxt.bitCnt = 5'd0;
    end else if (csRise) begin
      st_nxt.frame = FR_IDLE;
    end

    // Register writes at the end of a complete frame
    if (frameDone && !cmdAddr[READ_FLAG_BIT]) begin
      case (cmdAddr[6:0])
        ADDR_BRIGHT_01: st_nxt.bright01 = cmdData; // [R7] [R8]
        ADDR_BRIGHT_23: st_nxt.bright23 = cmdData; // [R7] [R8]
        ADDR_SCAN: st_nxt.scanLimit = cmdData; // [R5] [R6]
        default: begin
        end
      endcase
    end
    if (glyphWrite && cmdData[7]) begin
      st_nxt.fontPtr = (cmdData >= PTR_INVALID) ? PTR_FIRST : cmdData; // [R1] [R9]
    end else if ((glyphWrite && !cmdData[7]) || glyphRead) begin
      st_nxt.fontPtr = ptrNext; // [R2] [R10]
    end

    // PWM slots; pair changes only at the end of a 16-slot period
    st_nxt.divCnt = slotTick ? 8'd0 : st_r.divCnt + 8'd1;
    if (slotTick) begin
      st_nxt.slot = st_r.slot + 4'd1;
      if (st_r.slot == SLOT_LAST) begin
        st_nxt.pairSel = st_r.scanLimit[SCAN_FOUR_BIT] ? ~st_r.pairSel : 1'b0; // [R5] [R6]
      end
    end
  end

  // Sync stages reset high/idle so no false edge follows reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.sclkSync <= 3'b000;
      st_r.csSync <= 3'b111;
      st_r.frame <= FR_IDLE;
      st_r.bright01 <= BRIGHT_RESET;
      st_r.bright23 <= BRIGHT_RESET;
      st_r.scanLimit <= SCAN_RESET;
      st_r.fontPtr <= PTR_FIRST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spiDout = st_r.shiftOut[7];
  assign digitDrive = st_r.digitOn;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_PTR_LOAD: assert property ( // [R1]
    glyphWrite && cmdData[7] && cmdData < PTR_INVALID |=> st_r.fontPtr == $past(cmdData))
    else $error("pointer load did not take the written value");
  AST_FONT_STORE: assert property ( // [R2]
    glyphWrite && !cmdData[7] |-> fontBus.wrEn && fontBus.addr == st_r.fontPtr[6:0]
      ##1 st_r.fontPtr != $past(st_r.fontPtr))
    else $error("font data write did not store and advance");
  AST_PTR_RANGE: assert property ( // [R3]
    st_r.fontPtr >= PTR_FIRST && st_r.fontPtr <= PTR_LAST)
    else $error("font pointer outside glyph area");
  AST_PAIR_ONLY: assert property ( // [R5]
    !$past(st_r.scanLimit[SCAN_FOUR_BIT]) |-> digitDrive[3:2] == 2'b00)
    else $error("digits 2 or 3 driven with two-digit scan");
  AST_PAIR_SWAP: assert property ( // [R6]
    slotTick && st_r.slot == SLOT_LAST && st_r.scanLimit[SCAN_FOUR_BIT]
      |=> st_r.pairSel != $past(st_r.pairSel))
    else $error("four-digit scan did not alternate pairs");
  AST_DUTY_LOW: assert property ( // [R7]
    digitDrive[0] |-> {1'b0, $past(st_r.slot)} < lmf_duty($past(st_r.bright01[3:0])))
    else $error("digit 0 on beyond its duty");
  // Skips the first edge after reset: the reset edge forced the drive low
  AST_DUTY_HIGH: assert property ( // [R8]
    !$past(sys_rst) && $past(st_r.pairSel) == 1'b0
      && {1'b0, $past(st_r.slot)} < lmf_duty($past(st_r.bright01[7:4]))
      |-> digitDrive[1])
    else $error("digit 1 off inside its duty");
  AST_PTR_WRAP: assert property ( // [R9]
    (glyphRead || (glyphWrite && !cmdData[7])) && st_r.fontPtr == PTR_LAST
      |=> st_r.fontPtr == PTR_FIRST)
    else $error("pointer did not wrap to glyph base");
  AST_READ_MSB: assert property ( // [R10]
    st_r.frame == FR_DATA && sclkFall && st_r.bitCnt == ADDR_BITS && st_r.shiftIn[7:0] == 8'h85
      |=> !spiDout ##1 st_r.fontPtr == $past(st_r.fontPtr, 2))
    else $error("font read answer has top bit set or pointer moved early");

endmodule

// file: dv/lmf_host_model.sv
// Host side of the serial register port: a mode-0 master, MSB first.
// Assumes the register block samples its pins through two-flop synchronizers.
`timescale 1ns/1ps
module lmf_host_model (
  input wire logic clock,
  output logic spiClk,
  output logic spiCsN,
  output logic spiDin,
  input wire logic spiDout
);
  // ----------------------------------------------------------------
  // Idle pin levels
  // ----------------------------------------------------------------
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDin = 1'b0;
  end

  // ----------------------------------------------------------------
  // One 16-bit frame: address byte then data byte
  // ----------------------------------------------------------------
  // Five clocks per phase, so each level outlives the synchronizer delay
  task automatic frame(input logic [15:0] bits, output logic [7:0] ans);
    int i;
    ans = 8'h00;
    @(posedge clock);
    spiCsN <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      spiDin <= bits[i]; // Address first, then data
      repeat (5) @(posedge clock);
      if (i < 8) begin
        ans = {ans[6:0], spiDout}; // Answer bit settled before the rise
      end
      spiClk <= 1'b1;
      repeat (5) @(posedge clock);
      spiClk <= 1'b0;
    end
    repeat (5) @(posedge clock);
    spiCsN <= 1'b1;
    spiDin <= ~bits[0]; // Released line must not keep the last bit
    repeat (8) @(posedge clock);
  endtask
endmodule

// file: dv/test_lmf_regs.sv
// Self-checking bench of the register block against a behavioural model.
// Assumes the host model keeps every frame within the serial timing limits.
`timescale 1ns/1ps
module test_lmf_regs;
  import lmf_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic spiClk;
  logic spiCsN;
  logic spiDin;
  logic spiDout;
  logic [3:0] digitDrive;
  int num_errors = 0;
  int n_compared = 0;
  int font[0:FONT_ENTRIES-1];
  int mreg[0:3];
  int ptr = 'h80;
  logic [15:0] cnt[0:3];
  logic [7:0] got;
  logic [7:0] exp;
  int k;
  int c;
  int ex[0:4] = '{'h42, 'h61, 'h51, 'h49, 'h46};

  always #20 clock = ~clock;

  lmf_regs dut (.clock(clock), .sys_rst(sys_rst), .spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin),
    .spiDout(spiDout), .digitDrive(digitDrive));
  lmf_host_model host (.clock(clock), .spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin), .spiDout(spiDout));

  // ----------------------------------------------------------------
  // Comparison, model-driven bus tasks, closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic wr(input int a, input int d);
    logic [7:0] ans;
    host.frame({a[7:0], d[7:0]}, ans);
    if (a >= 1 && a <= 3) mreg[a] = d;
    else if (a == 5 && d >= 'h80) ptr = (d >= 'hF8) ? 'h80 : d;
    else if (a == 5) begin
      font[ptr - 'h80] = d & 'h7F;
      ptr = (ptr == 'hF7) ? 'h80 : ptr + 1;
    end
  endtask

  // Unmapped reads answer zero, a choice of this design
  task automatic rd(input int a);
    host.frame({a[7:0], 8'h00}, got);
    exp = 8'h00;
    if (a >= 'h81 && a <= 'h83) exp = 8'(mreg[a - 'h80]);
    if (a == 'h85) begin
      exp = 8'(font[ptr - 'h80]);
      ptr = (ptr == 'hF7) ? 'h80 : ptr + 1;
    end
  endtask

  // Window spans whole scan periods, so the count is phase independent
  task automatic pwm_check;
    int n;
    int code;
    int d;
    repeat (2048) @(posedge clock);
    for (n = 0; n < 4; n++) cnt[n] = '0;
    repeat (2048) begin
      @(posedge clock);
      for (n = 0; n < 4; n++) cnt[n] = cnt[n] + digitDrive[n];
    end
    for (n = 0; n < 4; n++) begin
      code = (mreg[1 + n / 2] >> (4 * (n % 2))) & 15;
      d = (code == 15) ? 15 : code + 1;
      if (mreg[3] & 1) check(cnt[n], 16'(d * SLOT_CYCLES));
      else check(cnt[n], (n < 2) ? 16'(d * 2 * SLOT_CYCLES) : 16'h0000);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: about twice the expected run length
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    c = $urandom(32'hBCD8);
    foreach (font[i]) font[i] = 0;
    foreach (mreg[i]) mreg[i] = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    for (k = 'h81; k <= 'h83; k++) begin
      rd(k);
      check(got, exp);
    end
    $display("test reset_values done");
    // Glyph two from the storage example, then glyphs zero and one random
    wr(5, 'h8A);
    for (c = 0; c < 5; c++) wr(5, ex[c]);
    for (k = 0; k < 2; k++) begin
      wr(5, 'h80 + 5 * k);
      for (c = 0; c < 5; c++) wr(5, $urandom % 128);
    end
    wr(5, 'h80);
    for (c = 0; c < 16; c++) begin
      rd('h85);
      check(got, exp);
    end
    $display("test glyph_load done");
    // Pointer wrap at the top and invalid pointer loads
    wr(5, 'hF6);
    wr(5, 'h11);
    wr(5, 'h22);
    rd('h85);
    check(got, exp);
    wr(5, 'hF7);
    rd('h85);
    check(got, exp);
    rd('h85);
    check(got, exp);
    wr(5, 'hF8 + $urandom % 8);
    rd('h85);
    check(got, exp);
    // Unmapped writes leave the pointer alone
    wr(4, 'h8A);
    wr(6, 'h8A);
    rd('h84);
    check(got, exp);
    rd('h85);
    check(got, exp);
    $display("test pointer_wrap done");
    // Every brightness code once, four digits scanned
    for (k = 0; k < 4; k++) begin
      wr(1, (4 * k + 1) * 16 + 4 * k);
      wr(2, (4 * k + 3) * 16 + 4 * k + 2);
      wr(3, 1); // Scan set only between PWM windows; no shutdown state here
      for (c = 'h81; c <= 'h83; c++) begin
        rd(c);
        check(got, exp);
      end
      pwm_check;
    end
    // Upper scan bits set but bit zero clear: two digits only
    wr(3, 'hFE); // Settling wait in pwm_check stands in for shutdown
    wr(1, $urandom % 256);
    wr(2, $urandom % 256);
    pwm_check;
    $display("test brightness_scan done");
    wrap_up;
  end
endmodule
